/* File: hw/asa_pkg.sv */
// Shared types, constants and decoders for the serial adapter core.
// Assumes a single 100 MHz clock; all pins are sampled on it.
package asa_pkg;
   // Divide select codes
   localparam logic [1:0] DIV_1      = 2'h0;
   localparam logic [1:0] DIV_16     = 2'h1;
   localparam logic [1:0] DIV_64     = 2'h2;
   localparam logic [1:0] DIV_MRESET = 2'h3;
   // Clock ticks per bit minus one, and per half bit minus one
   localparam logic [5:0] FULL16_M1  = 6'h0F;
   localparam logic [5:0] FULL64_M1  = 6'h3F;
   localparam logic [5:0] HALF16_M1  = 6'h07;
   localparam logic [5:0] HALF64_M1  = 6'h1F;
   // Transmit control codes
   localparam logic [1:0] TXC_IRQ_ON  = 2'h1;
   localparam logic [1:0] TXC_RTS_OFF = 2'h2;
   localparam logic [1:0] TXC_BREAK   = 2'h3;
   // Power-up control value: held in master reset
   localparam logic [7:0] CTRL_RESET  = 8'h03;
   localparam logic       MARK        = 1'b1;
   localparam logic       SPACE       = 1'b0;
   localparam logic [3:0] DATA7       = 4'h7;
   localparam logic [3:0] DATA8       = 4'h8;

   typedef struct packed {
      logic       rx_irq_en;
      logic [1:0] tx_ctl;
      logic [2:0] frame_sel;
      logic [1:0] div_sel;
   } asa_ctrl_t;

   typedef struct packed {
      logic irq;
      logic parity_err;
      logic rx_overrun;
      logic frame_err;
      logic cts;
      logic carrier_lost;
      logic tx_holding_empty;
      logic rx_holding_full;
   } asa_status_t;

   typedef struct packed {
      logic       e;
      logic       reg_sel;
      logic       rw;
      logic       cs0;
      logic       cs1;
      logic       cs2_n;
      logic [7:0] data;
      logic       rxd;
      logic       tx_clk;
      logic       rx_clk;
      logic       cts_n;
      logic       carrier_lost;
   } asa_pins_t;

   typedef struct packed {
      logic eight;
      logic par_en;
      logic odd;
      logic two_stop;
   } asa_frame_t;

   // Word select decode, shared by both directions
   function automatic asa_frame_t asa_frame(input logic [2:0] f);
      asa_frame_t r;
      r.eight    = f[2];
      r.par_en   = !(f[2] && !f[1]);
      r.odd      = f[0];
      r.two_stop = !f[1] && !(f[2] && f[0]);
      return r;
   endfunction : asa_frame

   // Reload value of the bit counter for a divide setting
   function automatic logic [5:0] asa_ratio_m1(input logic [1:0] d,
                                               input logic      half);
      logic [5:0] r;
      r = '0;
      if (d == DIV_16)
         r = half ? HALF16_M1 : FULL16_M1;
      else if (d == DIV_64)
         r = half ? HALF64_M1 : FULL64_M1;
      return r;
   endfunction : asa_ratio_m1
endpackage : asa_pkg

/* File: hw/asa_tx_shift.sv */
// Transmit shifter: serialises one character per load.
// Assumes tick_i is a one-cycle pulse per falling transmit clock edge.
`timescale 1ns/1ps
`default_nettype none
module asa_tx_shift
   import asa_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        init_i,
   input  wire logic        tick_i,
   input  wire logic [1:0]  div_sel_i,
   input  wire asa_frame_t  frame_i,
   input  wire logic        load_valid_i,
   input  wire logic [7:0]  load_data_i,
   output logic             load_ready_o,
   output logic             bit_o
);
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} asa_tx_state_t;
   asa_tx_state_t state;
   logic [5:0]    cnt;
   logic [3:0]    pos;
   logic [7:0]    data;
   logic [3:0]    nd;
   logic [3:0]    last;
   logic [3:0]    pos_m1;
   logic          next_bit;

   // Frame read live so format changes act at once
   assign nd     = frame_i.eight ? DATA8 : DATA7;
   assign last   = nd + {3'h0, frame_i.par_en} + (frame_i.two_stop ? 4'h2
                                                                  : 4'h1);
   assign pos_m1 = pos - 4'h1;
   // Idle shifter takes a character on the very next clock
   assign load_ready_o = (state == TX_IDLE) && !init_i;

   // Bit sequencer
   always_ff @(posedge clk_i) begin
      if (!resetn_i || init_i) begin
         state <= TX_IDLE;
         cnt   <= '0;
         pos   <= '0;
         data  <= '0;
      end else begin
         unique case (state)
            TX_IDLE: begin
               if (load_valid_i) begin
                  data  <= load_data_i;
                  pos   <= '0;
                  cnt   <= asa_ratio_m1(div_sel_i, 1'b0);
                  state <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tick_i) begin
                  if (cnt != 6'h00)
                     cnt <= cnt - 6'h01;
                  else begin
                     cnt <= asa_ratio_m1(div_sel_i, 1'b0);
                     if (pos == last)
                        state <= TX_IDLE;
                     else
                        pos <= pos + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Line level for the current position; parity after data
   always_comb begin
      next_bit = MARK;
      if (state == TX_SEND) begin
         if (pos == 4'h0)
            next_bit = SPACE;
         else if (pos <= nd)
            next_bit = data[pos_m1[2:0]];
         else if (frame_i.par_en && pos == nd + 4'h1)
            next_bit = ^(data & {frame_i.eight, 7'h7F}) ^ frame_i.odd;
      end
   end

   // Registered line output
   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         bit_o <= MARK;
      else
         bit_o <= next_bit;
   end
endmodule : asa_tx_shift
`default_nettype wire

/* File: hw/asa_core.sv */
// Asynchronous serial adapter core: bus registers, receiver, modem lines.
// Assumes every pin is asynchronous to clk_i and slower than 10 ns edges;
// the enable strobe is seen through a two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Receiver self-synchronises in x16 and x64
// - Clear-to-send high hides transmit empty
// - Request-to-send low unless control reads 10
// - Transmit control: irq enable, break, request
// - Carrier lost holds receiver initialised
// - Carrier lost rising edge requests interrupt
// - Transmit write captured at strobe fall
// - Transmit write clears transmit empty
// - Held character moves to shifter promptly
// - Complete character loads empty receive holding
// - Receive read clears full, keeps data
// - Full receive holding blocks new transfer
// - Write-only eight-bit control register
// - Read-only status register
// - Divide field: 1, 16, 64, reset
// - Master reset clears status, keeps control
// - Word select encodes length, parity, stops
// - Format changes act immediately
// - Control bit 7 enables receive interrupts
// - Status bit 0 is receive full
// - Status bit 2 latches carrier loss
// - Status bit 5 flags overrun
// - Status bit 4 flags missing stop
// - Status bit 6 flags parity mismatch
// - Status bit 7 mirrors interrupt output
module asa_core
   import asa_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        bus_e_i,
   input  wire logic        reg_sel_i,
   input  wire logic        rw_i,
   input  wire logic        cs0_i,
   input  wire logic        cs1_i,
   input  wire logic        cs2_n_i,
   input  wire logic [7:0]  data_i,
   output logic      [7:0]  data_o,
   output logic             data_oe_o,
   output logic             irq_n_o,
   output logic             irq_oe_o,
   input  wire logic        rx_data_i,
   output logic             tx_data_o,
   input  wire logic        tx_clk_i,
   input  wire logic        rx_clk_i,
   input  wire logic        cts_n_i,
   input  wire logic        carrier_lost_i,
   output logic             rts_n_o
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asa_rx_state_t;

   asa_pins_t     pin_now;
   asa_pins_t     pin_meta;
   asa_pins_t     pin_sync;
   logic          e_last;
   logic          txc_last;
   logic          rxc_last;
   logic          cl_last;
   logic          selected;
   logic          strobe;
   logic          wr_tx;
   logic          rd_rx;
   logic          wr_ctl;
   logic          rd_st;
   logic          tx_tick;
   logic          rx_tick;
   logic          cl_rise;
   logic          mreset;
   logic          rx_hold;
   asa_ctrl_t     ctrl;
   asa_frame_t    frame;
   asa_status_t   status;
   logic [7:0]    tx_holding_reg;
   logic          tx_full;
   logic          tx_ready;
   logic          tx_take;
   logic          tx_bit;
   logic          tx_holding_empty_shown;
   asa_rx_state_t rx_state;
   logic [5:0]    rx_cnt;
   logic [3:0]    rx_pos;
   logic [3:0]    rx_nd;
   logic [3:0]    rx_last;
   logic [7:0]    rx_shift;
   logic          rx_par;
   logic          rx_done;
   logic          rx_stop_ok;
   logic          rx_pe;
   logic [7:0]    rx_holding_reg;
   logic          rx_full;
   logic          rx_overrun;
   logic          ovr_pend;
   logic          frame_err;
   logic          parity_err;
   logic          cl_latch;
   logic          st_seen;
   logic          tx_irq;
   logic          rx_irq;
   logic          irq_q;

   assign pin_now = {bus_e_i, reg_sel_i, rw_i, cs0_i, cs1_i, cs2_n_i,
                     data_i, rx_data_i, tx_clk_i, rx_clk_i, cts_n_i,
                     carrier_lost_i};

   // Two-stage synchroniser for every pin
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_now;
         pin_sync <= pin_meta;
      end
   end

   // Previous values for edge detection, only on synchronised pins
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         e_last   <= 1'b0;
         txc_last <= 1'b0;
         rxc_last <= 1'b0;
         cl_last  <= 1'b0;
      end else begin
         e_last   <= pin_sync.e;
         txc_last <= pin_sync.tx_clk;
         rxc_last <= pin_sync.rx_clk;
         cl_last  <= pin_sync.carrier_lost;
      end
   end

   assign selected = pin_sync.cs0 && pin_sync.cs1 && !pin_sync.cs2_n;
   assign strobe   = e_last && !pin_sync.e && selected;
   assign wr_tx    = strobe && pin_sync.reg_sel && !pin_sync.rw;
   assign rd_rx    = strobe && pin_sync.reg_sel && pin_sync.rw;
   assign wr_ctl   = strobe && !pin_sync.reg_sel && !pin_sync.rw;
   assign rd_st    = strobe && !pin_sync.reg_sel && pin_sync.rw;
   assign tx_tick  = txc_last && !pin_sync.tx_clk;
   assign rx_tick  = !rxc_last && pin_sync.rx_clk;
   assign cl_rise  = !cl_last && pin_sync.carrier_lost;
   // divide code 11 is master reset
   assign mreset   = (ctrl.div_sel == DIV_MRESET);
   // carrier loss holds receiver in init
   assign rx_hold  = mreset || pin_sync.carrier_lost;
   assign frame    = asa_frame(ctrl.frame_sel);

   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         ctrl <= CTRL_RESET;
      else if (wr_ctl)
         ctrl <= pin_sync.data;
   end

   // write fills holding; shifter take empties it
   assign tx_take = tx_full && tx_ready;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_holding_reg <= '0;
         tx_full        <= 1'b0;
      end else if (mreset) begin
         tx_full <= 1'b0;
      end else if (wr_tx) begin
         tx_holding_reg <= pin_sync.data;
         tx_full        <= 1'b1;
      end else if (tx_take) begin
         tx_full <= 1'b0;
      end
   end

   // empty hidden by clear-to-send high or reset
   assign tx_holding_empty_shown = !tx_full && !pin_sync.cts_n && !mreset;

   // Shifter reads the live frame, so it shares the decoder
   asa_tx_shift u_tx (
      .clk_i        (clk_i),
      .resetn_i     (resetn_i),
      .init_i       (mreset),
      .tick_i       (tx_tick),
      .div_sel_i    (ctrl.div_sel),
      .frame_i      (frame),
      .load_valid_i (tx_full),
      .load_data_i  (tx_holding_reg),
      .load_ready_o (tx_ready),
      .bit_o        (tx_bit)
   );

   // break forces space; request follows control
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_data_o <= MARK;
         rts_n_o   <= 1'b0;
      end else begin
         tx_data_o <= (ctrl.tx_ctl == TXC_BREAK) ? SPACE : tx_bit;
         rts_n_o   <= (ctrl.tx_ctl == TXC_RTS_OFF);
      end
   end

   assign rx_nd   = frame.eight ? DATA8 : DATA7;
   assign rx_last = rx_nd + {3'h0, frame.par_en};

   // start detect and half-bit check; centre sampling
   always_ff @(posedge clk_i) begin
      if (!resetn_i || rx_hold) begin
         rx_state   <= RX_IDLE;
         rx_cnt     <= '0;
         rx_pos     <= '0;
         rx_shift   <= '0;
         rx_par     <= 1'b0;
         rx_done    <= 1'b0;
         rx_stop_ok <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (rx_tick) begin
            unique case (rx_state)
               RX_IDLE: begin
                  if (pin_sync.rxd == SPACE) begin
                     rx_pos   <= '0;
                     rx_shift <= '0;
                     // Divide-by-one trusts the external clock alignment
                     rx_state <= (ctrl.div_sel == DIV_1) ? RX_BITS
                                                          : RX_START;
                     rx_cnt   <= asa_ratio_m1(ctrl.div_sel, 1'b1);
                  end
               end
               RX_START: begin
                  if (rx_cnt != 6'h00)
                     rx_cnt <= rx_cnt - 6'h01;
                  else if (pin_sync.rxd == SPACE) begin
                     rx_cnt   <= asa_ratio_m1(ctrl.div_sel, 1'b0);
                     rx_state <= RX_BITS;
                  end else
                     rx_state <= RX_IDLE;   // False start dropped
               end
               RX_BITS: begin
                  if (rx_cnt != 6'h00)
                     rx_cnt <= rx_cnt - 6'h01;
                  else begin
                     rx_cnt <= asa_ratio_m1(ctrl.div_sel, 1'b0);
                     rx_pos <= rx_pos + 4'h1;
                     if (rx_pos < rx_nd)
                        rx_shift[rx_pos[2:0]] <= pin_sync.rxd;
                     else if (rx_pos < rx_last)
                        rx_par <= pin_sync.rxd;
                     if (rx_pos == rx_last) begin
                        rx_done    <= 1'b1;
                        rx_stop_ok <= pin_sync.rxd;
                        rx_state   <= RX_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign rx_pe = frame.par_en && ((^rx_shift ^ rx_par) != frame.odd);

   // load into empty holding; block while full
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_holding_reg <= '0;
         rx_full        <= 1'b0;
         rx_overrun     <= 1'b0;
         ovr_pend       <= 1'b0;
         frame_err      <= 1'b0;
         parity_err     <= 1'b0;
      end else if (rx_hold) begin
         rx_full    <= 1'b0;
         rx_overrun <= 1'b0;
         ovr_pend   <= 1'b0;
         frame_err  <= 1'b0;
         parity_err <= 1'b0;
      end else begin
         // overrun shows after the last good character is read
         if (rd_rx) begin
            if (ovr_pend) begin
               rx_overrun <= 1'b1;
               ovr_pend   <= 1'b0;
            end else begin
               rx_full    <= 1'b0;
               rx_overrun <= 1'b0;
            end
         end
         // A load in the read cycle wins over the clear
         if (rx_done) begin
            if (!rx_full || (rd_rx && !ovr_pend)) begin
               rx_holding_reg <= rx_shift;
               rx_full        <= 1'b1;
               frame_err      <= !rx_stop_ok;
               parity_err     <= rx_pe;
            end else
               ovr_pend <= 1'b1;
         end
      end
   end

   // carrier loss latch, cleared by status then data read
   always_ff @(posedge clk_i) begin
      if (!resetn_i || mreset) begin
         cl_latch <= 1'b0;
         st_seen  <= 1'b0;
      end else begin
         if (rd_st && cl_latch)
            st_seen <= 1'b1;
         if (rd_rx && st_seen) begin
            cl_latch <= 1'b0;
            st_seen  <= 1'b0;
         end
         // new edge wins over a clear in the same cycle
         if (cl_rise)
            cl_latch <= 1'b1;
      end
   end

   assign tx_irq = (ctrl.tx_ctl == TXC_IRQ_ON) && tx_holding_empty_shown;
   // receive sources gated by control bit 7
   assign rx_irq = ctrl.rx_irq_en && (rx_full || rx_overrun || cl_latch);

   // one flop feeds both pin and status bit
   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         irq_q <= 1'b0;
      else
         irq_q <= tx_irq || rx_irq;
   end
   assign irq_oe_o = irq_q;
   assign irq_n_o  = !irq_q;   // Open drain: only low is driven

   // status assembly; bit 2 follows a still-high input
   assign status = '{irq:              irq_q,
                     parity_err:       parity_err,
                     rx_overrun:       rx_overrun,
                     frame_err:        frame_err,
                     cts:              pin_sync.cts_n,
                     carrier_lost:     cl_latch || pin_sync.carrier_lost,
                     tx_holding_empty: tx_holding_empty_shown,
                     rx_holding_full:  rx_full};

   // Read data registered; register select picks receive holding or status
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         data_o    <= '0;
         data_oe_o <= 1'b0;
      end else begin
         data_o    <= pin_sync.reg_sel ? rx_holding_reg : status;
         data_oe_o <= selected && pin_sync.rw && pin_sync.e;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_cts_hides_empty:
      assert property (pin_sync.cts_n |-> !status.tx_holding_empty)
      else $error("transmit empty shown while clear-to-send high");
   chk_rts_follows_ctl:
      assert property (##1 (rts_n_o == ($past(ctrl.tx_ctl) == TXC_RTS_OFF)))
      else $error("request-to-send does not match control");
   chk_break_space:
      assert property ((ctrl.tx_ctl == TXC_BREAK) [*2] |-> tx_data_o == SPACE)
      else $error("break level not on serial output");
   chk_carrier_inhibit:
      assert property (pin_sync.carrier_lost |=> !rx_full && !rx_done)
      else $error("receiver active while carrier lost");
   chk_tx_write_full:
      assert property (wr_tx && !mreset |=> tx_full && !tx_holding_empty_shown)
      else $error("transmit write did not mark holding full");
   chk_rx_read_clear:
      assert property (rd_rx && !ovr_pend && !rx_done && !rx_hold
                       |=> !rx_full && $stable(rx_holding_reg))
      else $error("receive read did not clear full flag");
   chk_rx_no_overwrite:
      assert property (rx_full && !rd_rx && !rx_hold
                       |=> $stable(rx_holding_reg))
      else $error("full receive holding was overwritten");
   chk_mreset_clears:
      assert property (mreset && !wr_ctl |=> !rx_full && !rx_overrun
                       && !cl_latch
                       && $stable(ctrl.frame_sel))
      else $error("master reset left status set");
   chk_carrier_latch:
      assert property (cl_rise && !mreset |=> status.carrier_lost ##1
                       status.carrier_lost)
      else $error("carrier loss not latched");
   chk_irq_mirror:
      assert property (status.irq == !irq_n_o && irq_oe_o == status.irq)
      else $error("interrupt bit and pin disagree");
   chk_irq_cause:
      assert property ((tx_irq || rx_irq) |=> irq_oe_o)
      else $error("interrupt source without request");
endmodule : asa_core
`default_nettype wire

/* File: verification/asa_modem.sv */
// Modem model: bit clocks, serial data and modem status lines.
// Receive ticks per bit set by ratio; clocks stand still outside frames.
`timescale 1ns/1ps
`default_nettype none
module asa_modem (
   input  wire logic txd_i,
   output var logic  rxd_o,
   output var logic  tx_clk_o,
   output var logic  rx_clk_o,
   output var logic  cts_n_o,
   output var logic  carrier_lost_o
);
   int ratio;   // Receive clock ticks per bit
   // Idle: mark on the line, clear to send, carrier present
   initial begin
      rxd_o = 1'b1;
      tx_clk_o = 1'b1;
      rx_clk_o = 1'b0;
      cts_n_o = 1'b0;
      carrier_lost_o = 1'b0;
      ratio = 1;
   end

   // Modem status levels
   task automatic lines(input logic c, input logic d);
      cts_n_o = c;
      carrier_lost_o = d;
   endtask : lines

   // Bits change away from the rising sample edge, LSB first
   task automatic send(input logic [10:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_o = v[i];
         repeat (ratio) begin
            #100 rx_clk_o = 1'b1;
            #100 rx_clk_o = 1'b0;
         end
      end
      rxd_o = 1'b1;
   endtask : send

   // Start bit holds until our first falling edge; last fall ends stop
   task automatic get(output logic [8:0] b, output logic ok);
      int k;
      k = 0;
      while (txd_i !== 1'b0 && k < 500) begin
         #10;
         k++;
      end
      ok = (k < 500);
      for (int i = 0; i < 10; i++) begin
         #100 tx_clk_o = 1'b0;
         #100 tx_clk_o = 1'b1;
         if (i < 9)
            b[i] = txd_i;
      end
   endtask : get
endmodule : asa_modem
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the serial adapter core.
// Assumes chip selects active but for one deselect check; x1 mostly.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import asa_pkg::*;
   logic       clk_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic       e = 1'b0;
   logic       rs = 1'b0;
   logic       rw = 1'b1;
   logic [7:0] wd = 8'h00;
   logic       cs2n = 1'b0;
   logic       oe_seen = 1'b0;
   logic [7:0] rd, data_o;
   logic       oe, irq_oe, irq_n, txd, rxd, tck, rck, cts_n, dcd, rts_n;
   int         miscompares = 0;
   int         cmp_count = 0;

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   asa_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_e_i(e),
      .reg_sel_i(rs), .rw_i(rw), .cs0_i(1'b1), .cs1_i(1'b1),
      .cs2_n_i(cs2n), .data_i(wd), .data_o(data_o), .data_oe_o(oe),
      .irq_n_o(irq_n), .irq_oe_o(irq_oe), .rx_data_i(rxd),
      .tx_data_o(txd), .tx_clk_i(tck), .rx_clk_i(rck), .cts_n_i(cts_n),
      .carrier_lost_i(dcd), .rts_n_o(rts_n));
   asa_modem m (.txd_i(txd), .rxd_o(rxd), .tx_clk_o(tck),
      .rx_clk_o(rck), .cts_n_o(cts_n), .carrier_lost_o(dcd));

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string s, input logic [7:0] x,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== x) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", s, x, g);
      end
   endtask : chk

   // Inputs move 1 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step

   // Fields held well around the strobe; synchroniser needs 3 cycles
   task automatic bus(input logic r, input logic w, input logic [7:0] d);
      rs = r;
      rw = w;
      wd = d;
      step(4);
      e = 1'b1;
      step(6);
      rd = data_o;
      oe_seen = oe;
      e = 1'b0;
      step(5);
   endtask : bus

   task automatic stat(input logic [7:0] mk, input logic [7:0] x);
      bus(1'b0, 1'b1, 8'h00);
      chk("status", x, rd & mk);
      chk("bus drive", 8'h01, 8'(oe_seen));
   endtask : stat

   task automatic rdat(input logic [7:0] x);
      bus(1'b1, 1'b1, 8'h00);
      chk("rx data", x, rd);
   endtask : rdat

   task automatic wctl(input logic [7:0] c);
      bus(1'b0, 1'b0, c);
      chk("bus drive", 8'h00, 8'(oe_seen));
      step(3);
   endtask : wctl

   // A stuck transmitter ends the run
   task automatic txchk(input logic [7:0] x);
      logic [8:0] b;
      logic       ok;
      m.get(b, ok);
      if (!ok) begin
         miscompares++;
         report_and_stop();
      end
      chk("tx char", x, b[7:0]);
      chk("tx stop", 8'h01, 8'(b[8]));
   endtask : txchk

   task automatic t_reset();
      stat(8'h02, 8'h00);
      wctl(8'h03);
      cs2n = 1'b1;
      wctl(8'h14);
      cs2n = 1'b0;
      stat(8'h02, 8'h00);
      wctl(8'h14);
      stat(8'hFF, 8'h02);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ctl();
      for (int c = 0; c < 4; c++) begin
         wctl({1'b0, c[1:0], 5'h14});
         chk("rts", 8'(c == 2), 8'(rts_n));
         chk("break", 8'(c != 3), 8'(txd));
         chk("irq", 8'(c != 1), 8'(irq_n));
      end
      m.lines(1'b1, 1'b0);
      step(8);
      stat(8'h0A, 8'h08);
      m.lines(1'b0, 1'b0);
      wctl(8'h14);
      $display("test control done");
   endtask : t_ctl

   task automatic t_tx();
      bus(1'b1, 1'b0, 8'hA5);
      bus(1'b1, 1'b0, 8'h3C);
      stat(8'h02, 8'h00);
      txchk(8'hA5);
      stat(8'h02, 8'h02);
      txchk(8'h3C);
      $display("test tx done");
   endtask : t_tx

   task automatic t_rx();
      m.send({1'b1, 8'h5A, 1'b0}, 10);
      step(8);
      stat(8'h01, 8'h01);
      rdat(8'h5A);
      stat(8'h01, 8'h00);
      rdat(8'h5A);
      m.send({1'b1, 8'h11, 1'b0}, 10);
      m.send({1'b1, 8'h22, 1'b0}, 10);
      step(8);
      rdat(8'h11);
      stat(8'h21, 8'h21);
      bus(1'b1, 1'b1, 8'h00);
      stat(8'h21, 8'h00);
      $display("test rx done");
   endtask : t_rx

   task automatic t_err();
      wctl(8'h18);
      m.send({1'b1, 1'b1, 8'h03, 1'b0}, 11);
      step(8);
      stat(8'h51, 8'h41);
      rdat(8'h03);
      wctl(8'h14);
      m.send({1'b0, 8'h81, 1'b0}, 10);
      step(8);
      stat(8'h51, 8'h11);
      rdat(8'h81);
      $display("test errors done");
   endtask : t_err

   task automatic t_dcd();
      wctl(8'h94);
      m.send({1'b1, 8'h77, 1'b0}, 10);
      step(8);
      chk("irq", 8'h00, 8'(irq_n));
      m.lines(1'b0, 1'b1);
      step(8);
      stat(8'h85, 8'h84);
      chk("irq", 8'h00, 8'(irq_n));
      chk("irq drive", 8'h01, 8'(irq_oe));
      m.lines(1'b0, 1'b0);
      step(8);
      stat(8'h04, 8'h04);
      bus(1'b1, 1'b1, 8'h00);
      stat(8'h85, 8'h00);
      chk("irq", 8'h01, 8'(irq_n));
      chk("irq drive", 8'h00, 8'(irq_oe));
      $display("test carrier done");
   endtask : t_dcd

   // Divide by 16, seven bits odd parity: centre sampling
   task automatic t_x16();
      wctl(8'h0D);
      m.ratio = 16;
      m.send({1'b1, 1'b1, 7'h35, 1'b0}, 10);
      step(8);
      stat(8'h71, 8'h01);
      rdat(8'h35);
      m.ratio = 1;
      wctl(8'h14);
      $display("test x16 done");
   endtask : t_x16

   // Reset, then the scenarios in turn
   initial begin
      step(16);
      resetn_i = 1'b1;
      step(2);
      t_reset();
      t_ctl();
      t_tx();
      t_rx();
      t_err();
      t_x16();
      t_dcd();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
